// *** siomon_consts.vh ***
`ifndef SIOMON_CONSTS_VH
`define SIOMON_CONSTS_VH
// input signal numbers
`define SIOMON_IN_SERVO_ENABLE_INPUT      5'h00
`define SIOMON_IN_ALARM_RST   5'h01
`define SIOMON_IN_CW_BLOCK    5'h02
`define SIOMON_IN_CCW_BLOCK   5'h03
`define SIOMON_IN_ZERO_HOLD   5'h05
`define SIOMON_IN_RATIO_SEL   5'h06
`define SIOMON_IN_LOOP_SW     5'h09
`define SIOMON_IN_DEV_RST     5'h0A
`define SIOMON_IN_SPD_A       5'h0C
`define SIOMON_IN_SPD_B       5'h0D
// output signal numbers
`define SIOMON_OUT_FAULT      5'h01
`define SIOMON_OUT_POS_DONE   5'h02
`define SIOMON_OUT_BRAKE      5'h03
`define SIOMON_OUT_ZERO_SPD   5'h04
`define SIOMON_OUT_TRQ_LIM    5'h05
`define SIOMON_OUT_AT_SPEED   5'h09
// error codes, two bcd digits
`define SIOMON_ERR_NONE       8'h00
`define SIOMON_ERR_ENC_COMM   8'h21
`define SIOMON_ERR_OVER_DEV   8'h24
`define SIOMON_ERR_OVER_SPD   8'h26
`define SIOMON_ERR_DEV_OVF    8'h29
`define SIOMON_ERR_TRAVEL     8'h38
`define SIOMON_ERR_ENC_INDEX  8'h48
`define SIOMON_ERR_AUTO_REC   8'h95
// defaults
`define SIOMON_WIN_RESET      16'h000A
`define SIOMON_SPD_RESET      16'h03E8
`define SIOMON_STEP_MAX       16'h0010
`endif

// *** siomon_err_enc.v ***
`timescale 1ns/100ps
`default_nettype none
`include "siomon_consts.vh"
module siomon_err_enc
(
   input  wire       enc_comm_err,
   input  wire       over_dev_err,
   input  wire       over_spd_err,
   input  wire       dev_ovf_err,
   input  wire       travel_err,
   input  wire       enc_index_err,
   input  wire       auto_rec_err,
   output reg  [7:0] code,
   output reg        valid
);
   // priority encoder of protection events
   always @*
   begin
      valid = 1'b1;
      if (enc_comm_err)
         code = `SIOMON_ERR_ENC_COMM;
      else if (enc_index_err)
         code = `SIOMON_ERR_ENC_INDEX;
      else if (dev_ovf_err)
         code = `SIOMON_ERR_DEV_OVF;
      else if (over_dev_err)
         code = `SIOMON_ERR_OVER_DEV;
      else if (over_spd_err)
         code = `SIOMON_ERR_OVER_SPD;
      else if (auto_rec_err)
         code = `SIOMON_ERR_AUTO_REC;
      else if (travel_err)
         code = `SIOMON_ERR_TRAVEL;
      else
      begin
         code  = `SIOMON_ERR_NONE;
         valid = 1'b0;
      end
   end
endmodule // siomon_err_enc
`default_nettype wire

// *** siomon_tune_gen.v ***
`timescale 1ns/100ps
`default_nettype none
`include "siomon_consts.vh"
module siomon_tune_gen
#(
   parameter STEP_CYCLES = 1024
)
(
   input  wire        mclk,
   input  wire        nrst,
   input  wire        start,
   input  wire        abort,
   input  wire [2:0]  pattern,
   output reg         busy_q,
   output reg  [1:0]  move_q
);
   localparam ST_IDLE = 2'b00;
   localparam ST_RUN  = 2'b01;
   reg [1:0]  state_q;
   reg [31:0] cnt_q;
   reg [3:0]  step_q;
   reg [7:0]  pat_q;
   // pattern word: pairs of bits, 01 ccw, 10 cw, 00 hold
   function [7:0] pat_word;
      input [2:0] sel;
      begin
         case (sel)
            3'd0:    pat_word = 8'h66;
            3'd1:    pat_word = 8'h55;
            3'd2:    pat_word = 8'h99;
            3'd3:    pat_word = 8'hAA;
            3'd4:    pat_word = 8'h46;
            default: pat_word = 8'h64;
         endcase
      end
   endfunction
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 32'h0000_0000;
         step_q  <= 4'h0;
         pat_q   <= 8'h00;
         busy_q  <= 1'b0;
         move_q  <= 2'b00;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               move_q <= 2'b00;
               busy_q <= 1'b0;
               if (start)
               begin
                  pat_q   <= pat_word(pattern);
                  step_q  <= 4'h0;
                  cnt_q   <= 32'h0000_0000;
                  busy_q  <= 1'b1;
                  state_q <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               if (abort)
               begin
                  state_q <= ST_IDLE;
                  move_q  <= 2'b00;
                  busy_q  <= 1'b0;
               end
               else
               begin
                  move_q <= pat_q[2*step_q[1:0] +: 2];
                  if (cnt_q == STEP_CYCLES - 1)
                  begin
                     cnt_q  <= 32'h0000_0000;
                     step_q <= step_q + 4'h1;
                     if (step_q == 4'h3)
                        state_q <= ST_IDLE;
                  end
                  else
                     cnt_q <= cnt_q + 32'h0000_0001;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // siomon_tune_gen
`default_nettype wire

// *** siomon_top.v ***
// Notes on behaviour
// - input 00 shows servo enable line
// - input 01 shows alarm reset line
// - limits 02/03 masked or active-open, torque off
// - zero hold: open line stops, shows 05
// - ratio select picks second numerator, shown
// - gain setup 0, open: pi, shown inactive
// - deviation reset clears counter, shown active
// - preset speed selects 0C/0D shown active
// - alarm turns fault output off, shown
// - output 02 within in-position window
// - output 03 follows brake release transistor
// - warning select chooses flag for shared line
// - speed mode: at-speed on position done line
// - low-active connector lines on when low
// - codes 24, 26, 29, 95 reported
// - encoder codes 21 and 48 distinct
// - travel limit raises its own code 38
// - confirmed settings apply, large changes stepped
// - tuning moves motor in selected pattern
// - reserved signal numbers never shown active
`timescale 1ns/100ps
`default_nettype none
`include "siomon_consts.vh"
module siomon_top
#(
   parameter TUNE_STEP_CYCLES = 1024,
   parameter DEV_W            = 24
)
(
   input  wire             mclk,
   input  wire             nrst,
   // host connector lines, low-active, low means on
   input  wire             servo_enable_input_n,
   input  wire             alarm_reset_input_n,
   input  wire             cw_travel_block_n,
   input  wire             ccw_travel_block_n,
   input  wire             zero_speed_hold_n,
   input  wire             ratio_select_n,
   input  wire             loop_setting_switch_n,
   input  wire             deviation_reset_input_n,
   input  wire             preset_speed_sel_a_n,
   input  wire             preset_speed_sel_b_n,
   // internal drive state
   input  wire             servo_alarm,
   input  wire             brake_release_on,
   input  wire             zero_speed_flag,
   input  wire             torque_limit_flag,
   input  wire             speed_mode,
   input  wire [15:0]      motor_speed,
   input  wire             position_step,
   input  wire             position_dir,
   input  wire             enc_comm_err,
   input  wire             over_dev_err,
   input  wire             over_spd_err,
   input  wire             dev_ovf_err,
   input  wire             enc_index_err,
   input  wire             auto_rec_err,
   // settings from console
   input  wire             travel_block_disable,
   input  wire             zero_speed_hold_select,
   input  wire             gain_switch_setup,
   input  wire             warning_output_select,
   input  wire [15:0]      set_in_position_window,
   input  wire [15:0]      set_speed_reached_threshold,
   input  wire             set_confirm,
   input  wire [2:0]       tuning_pattern_select,
   input  wire             tune_start,
   // outputs to host connector, low means on
   output reg              fault_output_n,
   output reg              position_done_output_n,
   output reg              brake_release_output_n,
   output reg              warning_output_n,
   // drive controls
   output reg              torque_enable,
   output reg              motor_stop,
   output reg              use_ratio_b,
   output reg              pi_mode,
   output reg  [1:0]       preset_speed_index,
   output reg  [DEV_W-1:0] deviation_q,
   output wire             tune_busy,
   output wire [1:0]       tune_move,
   // monitor
   output reg  [31:0]      in_status_q,
   output reg  [31:0]      out_status_q,
   output reg  [7:0]       error_code_q,
   output reg              error_valid_q,
   output reg  [15:0]      in_position_window_q,
   output reg  [15:0]      speed_reached_threshold_q
);
   wire            servo_enable_input;
   wire            alarm_reset_input;
   wire            cw_on;
   wire            ccw_on;
   wire            zhold_on;
   wire            ratio_on;
   wire            loop_on;
   wire            dev_rst;
   wire            spd_a;
   wire            spd_b;
   wire            cw_act;
   wire            ccw_act;
   wire            zhold_act;
   wire [DEV_W-1:0] dev_abs;
   wire            in_pos;
   wire            at_speed;
   wire            warn_on;
   wire [7:0]      err_code;
   wire            err_valid;
   reg  [31:0]     in_d;
   reg  [31:0]     out_d;
   reg  [15:0]     win_target_q;
   reg  [15:0]     spd_target_q;

   // step a setting toward its target by a bounded amount
   function [15:0] step_to;
      input [15:0] cur;
      input [15:0] tgt;
      begin
         if ({1'b0, tgt} > {1'b0, cur} + {1'b0, `SIOMON_STEP_MAX})
            step_to = cur + `SIOMON_STEP_MAX;
         else if ({1'b0, cur} > {1'b0, tgt} + {1'b0, `SIOMON_STEP_MAX})
            step_to = cur - `SIOMON_STEP_MAX;
         else
            step_to = tgt;
      end
   endfunction

   // low level on connector means on
   assign servo_enable_input   = ~servo_enable_input_n;
   assign alarm_reset_input    = ~alarm_reset_input_n;
   assign cw_on    = ~cw_travel_block_n;
   assign ccw_on   = ~ccw_travel_block_n;
   assign zhold_on = ~zero_speed_hold_n;
   assign ratio_on = ~ratio_select_n;
   assign loop_on  = ~loop_setting_switch_n;
   assign dev_rst  = ~deviation_reset_input_n;
   assign spd_a    = ~preset_speed_sel_a_n;
   assign spd_b    = ~preset_speed_sel_b_n;

   assign cw_act    = ~travel_block_disable & ~cw_on;
   assign ccw_act   = ~travel_block_disable & ~ccw_on;
   assign zhold_act = zero_speed_hold_select & ~zhold_on;

   assign dev_abs  = deviation_q[DEV_W-1] ? (~deviation_q + 1'b1) : deviation_q;
   assign in_pos   = (dev_abs <= {{(DEV_W-16){1'b0}}, in_position_window_q});
   assign at_speed = speed_mode & (motor_speed > speed_reached_threshold_q);
   assign warn_on  = warning_output_select ? torque_limit_flag : zero_speed_flag;

   siomon_err_enc u_err
   (
      .enc_comm_err  (enc_comm_err),
      .over_dev_err  (over_dev_err),
      .over_spd_err  (over_spd_err),
      .dev_ovf_err   (dev_ovf_err),
      .travel_err    (cw_act | ccw_act),
      .enc_index_err (enc_index_err),
      .auto_rec_err  (auto_rec_err),
      .code          (err_code),
      .valid         (err_valid)
   );

   siomon_tune_gen #(.STEP_CYCLES(TUNE_STEP_CYCLES)) u_tune
   (
      .mclk    (mclk),
      .nrst    (nrst),
      .start   (tune_start & servo_enable_input),
      .abort   (~servo_enable_input | servo_alarm | dev_rst | cw_act | ccw_act),
      .pattern (tuning_pattern_select),
      .busy_q  (tune_busy),
      .move_q  (tune_move)
   );

   // monitor bit vectors, reserved numbers stay zero
   always @*
   begin
      in_d  = 32'h0000_0000;
      out_d = 32'h0000_0000;
      in_d[`SIOMON_IN_SERVO_ENABLE_INPUT]     = servo_enable_input;
      in_d[`SIOMON_IN_ALARM_RST]  = alarm_reset_input;
      in_d[`SIOMON_IN_CW_BLOCK]   = cw_act;
      in_d[`SIOMON_IN_CCW_BLOCK]  = ccw_act;
      in_d[`SIOMON_IN_ZERO_HOLD]  = zhold_act;
      in_d[`SIOMON_IN_RATIO_SEL]  = ratio_on;
      in_d[`SIOMON_IN_LOOP_SW]    = loop_on;
      in_d[`SIOMON_IN_DEV_RST]    = dev_rst;
      in_d[`SIOMON_IN_SPD_A]      = spd_a;
      in_d[`SIOMON_IN_SPD_B]      = spd_b;
      out_d[`SIOMON_OUT_FAULT]    = servo_alarm;
      out_d[`SIOMON_OUT_POS_DONE] = ~speed_mode & in_pos;
      out_d[`SIOMON_OUT_BRAKE]    = brake_release_on;
      out_d[`SIOMON_OUT_ZERO_SPD] = ~warning_output_select & zero_speed_flag;
      out_d[`SIOMON_OUT_TRQ_LIM]  = warning_output_select & torque_limit_flag;
      out_d[`SIOMON_OUT_AT_SPEED] = at_speed;
   end

   // snapshot and drive outputs
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         in_status_q            <= 32'h0000_0000;
         out_status_q           <= 32'h0000_0000;
         error_code_q           <= `SIOMON_ERR_NONE;
         error_valid_q          <= 1'b0;
         fault_output_n         <= 1'b1;
         position_done_output_n <= 1'b1;
         brake_release_output_n <= 1'b1;
         warning_output_n       <= 1'b1;
         torque_enable          <= 1'b0;
         motor_stop             <= 1'b1;
         use_ratio_b            <= 1'b0;
         pi_mode                <= 1'b1;
         preset_speed_index     <= 2'b00;
      end
      else
      begin
         in_status_q   <= in_d;
         out_status_q  <= out_d;
         error_code_q  <= err_code;
         error_valid_q <= err_valid;
         // fault line on (low) while no alarm, off on alarm
         fault_output_n         <= servo_alarm;
         position_done_output_n <= ~(speed_mode ? at_speed : in_pos);
         brake_release_output_n <= ~brake_release_on;
         warning_output_n       <= ~warn_on;
         torque_enable          <= servo_enable_input & ~servo_alarm & ~cw_act & ~ccw_act;
         motor_stop             <= zhold_act | ~servo_enable_input;
         use_ratio_b            <= ratio_on;
         pi_mode                <= gain_switch_setup | ~loop_on;
         preset_speed_index     <= {spd_b, spd_a};
      end
   end

   // deviation counter
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
         deviation_q <= {DEV_W{1'b0}};
      else if (dev_rst)
         deviation_q <= {DEV_W{1'b0}};
      else if (position_step)
         deviation_q <= position_dir ? deviation_q - 1'b1 : deviation_q + 1'b1;
   end

   // confirmed settings, applied in bounded steps
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         win_target_q              <= `SIOMON_WIN_RESET;
         spd_target_q              <= `SIOMON_SPD_RESET;
         in_position_window_q      <= `SIOMON_WIN_RESET;
         speed_reached_threshold_q <= `SIOMON_SPD_RESET;
      end
      else
      begin
         if (set_confirm)
         begin
            win_target_q <= set_in_position_window;
            spd_target_q <= set_speed_reached_threshold;
         end
         in_position_window_q      <= step_to(in_position_window_q, win_target_q);
         speed_reached_threshold_q <= step_to(speed_reached_threshold_q, spd_target_q);
      end
   end
endmodule // siomon_top
`default_nettype wire

// *** siomon_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module siomon_props
#(
   parameter DEV_W = 24
)
(
   input wire logic             mclk,
   input wire logic             nrst,
   input wire logic             servo_enable_input_n,
   input wire logic             cw_travel_block_n,
   input wire logic             ccw_travel_block_n,
   input wire logic             deviation_reset_input_n,
   input wire logic             travel_block_disable,
   input wire logic             servo_alarm,
   input wire logic             torque_enable,
   input wire logic             fault_output_n,
   input wire logic             warning_output_n,
   input wire logic [DEV_W-1:0] deviation_q,
   input wire logic [31:0]      in_status_q,
   input wire logic [31:0]      out_status_q,
   input wire logic [15:0]      in_position_window_q
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   // two edges out of reset, so past values are live
   sequence warm_s;
      nrst ##1 nrst;
   endsequence
   sequence cw_open_s;
      warm_s ##0 ($past(cw_travel_block_n) && !$past(travel_block_disable));
   endsequence
   srv_shown_a: assert property (warm_s |->
      in_status_q[0] == !$past(servo_enable_input_n)) else $error("servo status wrong");
   limit_shown_a: assert property (warm_s |->
      in_status_q[3] == ($past(ccw_travel_block_n) && !$past(travel_block_disable)))
      else $error("limit status wrong");
   limit_torque_a: assert property (cw_open_s |-> !torque_enable)
      else $error("torque on at open limit");
   dev_clear_a: assert property (!deviation_reset_input_n |=> deviation_q == '0)
      else $error("deviation not cleared");
   fault_pin_a: assert property (warm_s |->
      fault_output_n == $past(servo_alarm) && out_status_q[1] == $past(servo_alarm))
      else $error("fault output wrong");
   warn_one_a: assert property (out_status_q[5:4] != 2'b11 &&
      warning_output_n == !(|out_status_q[5:4])) else $error("warning line wrong");
   reserved_off_a: assert property ((in_status_q & 32'hFFFF_C990) == 0 &&
      (out_status_q & 32'hFFFF_FDC1) == 0) else $error("reserved bit shown");
   set_slew_a: assert property (warm_s |->
      in_position_window_q <= $past(in_position_window_q) + 17'h0_0010 &&
      $past(in_position_window_q) <= in_position_window_q + 17'h0_0010)
      else $error("window step too large");
endmodule // siomon_props
bind siomon_top siomon_props #(.DEV_W(DEV_W)) siomon_props_inst (.*);
`default_nettype wire

// *** siomon_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module siomon_host_model
(
   input  wire logic [9:0] host_on,
   output logic            servo_enable_input_n,
   output logic            alarm_reset_input_n,
   output logic            cw_travel_block_n,
   output logic            ccw_travel_block_n,
   output logic            zero_speed_hold_n,
   output logic            ratio_select_n,
   output logic            loop_setting_switch_n,
   output logic            deviation_reset_input_n,
   output logic            preset_speed_sel_a_n,
   output logic            preset_speed_sel_b_n
);
   // a line that is on is pulled low
   assign {preset_speed_sel_b_n, preset_speed_sel_a_n, deviation_reset_input_n,
           loop_setting_switch_n, ratio_select_n, zero_speed_hold_n, ccw_travel_block_n,
           cw_travel_block_n, alarm_reset_input_n, servo_enable_input_n} = ~host_on;
endmodule // siomon_host_model
`default_nettype wire

// *** siomon_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module siomon_top_tb;
   logic        mclk = 1'b0, nrst = 1'b0;
   logic [9:0]  host_on = 10'h00D;
   logic        servo_enable_input_n, alarm_reset_input_n, cw_travel_block_n;
   logic        ccw_travel_block_n, zero_speed_hold_n, ratio_select_n, loop_setting_switch_n;
   logic        deviation_reset_input_n, preset_speed_sel_a_n, preset_speed_sel_b_n;
   logic        servo_alarm = 0, brake_release_on = 0, zero_speed_flag = 0;
   logic        torque_limit_flag = 0, speed_mode = 0, position_step = 0, position_dir = 0;
   logic        enc_comm_err = 0, over_dev_err = 0, over_spd_err = 0, dev_ovf_err = 0;
   logic        enc_index_err = 0, auto_rec_err = 0, travel_block_disable = 0;
   logic        zero_speed_hold_select = 0, gain_switch_setup = 0, warning_output_select = 0;
   logic        set_confirm = 0, tune_start = 0;
   logic [15:0] motor_speed = 16'h0000, set_in_position_window = 16'h000A;
   logic [15:0] set_speed_reached_threshold = 16'h03E8;
   logic [2:0]  tuning_pattern_select = 3'h0;
   logic        fault_output_n, position_done_output_n, brake_release_output_n;
   logic        warning_output_n, torque_enable, motor_stop, use_ratio_b, pi_mode;
   logic        tune_busy, error_valid_q;
   logic [1:0]  preset_speed_index, tune_move;
   logic [23:0] deviation_q;
   logic [31:0] in_status_q, out_status_q;
   logic [7:0]  error_code_q;
   logic [15:0] in_position_window_q, speed_reached_threshold_q;
   int          n_fail = 0, comparisons = 0;

   siomon_host_model siomon_host_model_inst (.*);
   siomon_top #(.TUNE_STEP_CYCLES(4), .DEV_W(24)) siomon_top_inst (.*);

   initial
   begin
      forever #4 mclk = ~mclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1)
      begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic t_inputs();
      logic [31:0] e;
      for (int m = 0; m < 4; m++)
         for (int i = 0; i < 10; i++)
         begin
            @(posedge mclk);
            host_on <= 10'h001 << i;
            travel_block_disable <= m[0];
            gain_switch_setup <= m[0];
            zero_speed_hold_select <= m[1];
            cyc(1);
            e = {18'h0_0000, host_on[9:8], 1'b0, host_on[7:6], 2'b00, host_on[5],
                 !host_on[4] && m[1], 1'b0, !host_on[3] && !m[0], !host_on[2] && !m[0],
                 host_on[1:0]};
            chk(in_status_q === e, "input status");
            chk(use_ratio_b === host_on[5], "ratio");
            chk(pi_mode === (m[0] || !host_on[6]), "pi mode");
            chk(preset_speed_index === host_on[9:8], "speed select");
            chk(torque_enable === 1'b0 || m[0] || host_on[3:2] === 2'b11, "torque");
            chk(motor_stop === 1'b1 || !m[1] || host_on[4], "stop");
         end
      @(posedge mclk);
      host_on <= 10'h00D;
      {travel_block_disable, gain_switch_setup, zero_speed_hold_select} <= 3'h0;
      $display("inputs done");
   endtask

   task automatic t_outputs();
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk);
         {servo_alarm, brake_release_on, warning_output_select} <= i[2:0];
         {zero_speed_flag, torque_limit_flag} <= {i[0] ^ i[1], !(i[0] ^ i[1])};
         cyc(1);
         chk(fault_output_n === servo_alarm && out_status_q[1] === servo_alarm, "fault");
         chk(brake_release_output_n === !brake_release_on &&
             out_status_q[3] === brake_release_on, "brake");
         chk((out_status_q[5:4] & ~{torque_limit_flag, zero_speed_flag}) === 2'b00 &&
             warning_output_n === !(|out_status_q[5:4]), "warning");
      end
      for (int i = 0; i < 2; i++)
      begin
         @(posedge mclk);
         {servo_alarm, speed_mode} <= 2'b01;
         motor_speed <= 16'h03E8 + i[15:0];
         cyc(1);
         chk(out_status_q[9] === i[0] && position_done_output_n === !i[0], "at speed");
      end
      @(posedge mclk);
      speed_mode <= 1'b0;
      $display("outputs done");
   endtask

   task automatic steps(input int n, input logic dir);
      @(posedge mclk);
      position_dir <= dir;
      position_step <= 1'b1;
      repeat (n) @(posedge mclk);
      position_step <= 1'b0;
      cyc(1);
   endtask

   task automatic t_deviation();
      steps(10, 1'b0);
      chk(deviation_q === 24'h00_000A && out_status_q[2] === 1'b1, "window edge");
      steps(1, 1'b0);
      chk(deviation_q === 24'h00_000B && out_status_q[2] === 1'b0, "window out");
      steps(12, 1'b1);
      chk(deviation_q === 24'hFF_FFFF && out_status_q[2] === 1'b1, "negative");
      @(posedge mclk);
      host_on[7] <= 1'b1;
      position_step <= 1'b1;
      cyc(1);
      chk(deviation_q === 24'h00_0000 && in_status_q[10] === 1'b1, "clear");
      @(posedge mclk);
      host_on[7] <= 1'b0;
      position_step <= 1'b0;
      $display("deviation done");
   endtask

   task automatic t_errors();
      logic [7:0] codes [6] = '{8'h21, 8'h48, 8'h29, 8'h24, 8'h26, 8'h95};
      for (int i = 0; i < 7; i++)
      begin
         @(posedge mclk);
         {auto_rec_err, over_spd_err, over_dev_err, dev_ovf_err, enc_index_err,
          enc_comm_err} <= 6'h3F << i;
         host_on[2] <= 1'b0;
         cyc(1);
         chk(error_code_q === (i < 6 ? codes[i] : 8'h38) &&
             error_valid_q === 1'b1, "error code");
      end
      @(posedge mclk);
      host_on[2] <= 1'b1;
      cyc(1);
      chk(error_code_q === 8'h00 && error_valid_q === 1'b0, "no error");
      $display("errors done");
   endtask

   task automatic t_settings();
      int n;
      @(posedge mclk);
      set_in_position_window <= 16'h0032;
      set_speed_reached_threshold <= 16'h0010;
      set_confirm <= 1'b1;
      @(posedge mclk);
      set_confirm <= 1'b0;
      cyc(1);
      chk(in_position_window_q === 16'h001A, "slew one");
      cyc(1);
      chk(in_position_window_q === 16'h002A, "slew two");
      cyc(1);
      chk(in_position_window_q === 16'h0032, "slew end");
      n = 0;
      while (speed_reached_threshold_q !== 16'h0010 && n < 100)
      begin
         cyc(1);
         n++;
      end
      chk(n == 59, "threshold");
      if (n == 100)
         results();
      $display("settings done");
   endtask

   task automatic t_tune();
      logic [7:0] w [8] = '{8'h66, 8'h55, 8'h99, 8'hAA, 8'h46, 8'h64, 8'h64, 8'h64};
      for (int s = 0; s < 9; s++)
      begin
         @(posedge mclk);
         tuning_pattern_select <= s[2:0];
         tune_start <= 1'b1;
         @(posedge mclk);
         tune_start <= 1'b0;
         cyc(3);
         if (s == 8)
         begin
            @(posedge mclk);
            host_on[0] <= 1'b0;
            cyc(2);
            chk(tune_busy === 1'b0 && tune_move === 2'b00, "abort");
            @(posedge mclk);
            host_on[0] <= 1'b1;
         end
         else
         begin
            for (int k = 0; k < 4; k++)
            begin
               chk(tune_busy === 1'b1 && tune_move === w[s][2*k +: 2], "move");
               cyc(4);
            end
            chk(tune_busy === 1'b0 && tune_move === 2'b00, "tune end");
         end
      end
      $display("tuning done");
   endtask

   initial
   begin
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      cyc(1);
      t_inputs();
      t_outputs();
      t_deviation();
      t_errors();
      t_settings();
      t_tune();
      results();
   end
endmodule // siomon_top_tb
`default_nettype wire
